// file: pkg/sar_params.svh
// constants for the successive-approximation conversion sequencer
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_RESOLUTION      16
`define SAR_CODE_MAX_POS    16'h7fff
`define SAR_CODE_MAX_NEG    16'h8000
`define SAR_CODE_MIDSCALE   16'h0000
`define SAR_SIGN_FLIP       16'h8000
`define SAR_CONV_RATE_SPS   500000
`define SAR_CLOCK_HZ        100000000
`define SAR_CONV_PERIOD_CYC (`SAR_CLOCK_HZ / `SAR_CONV_RATE_SPS)
`define SAR_DIV_DEFAULT     4
`define SAR_SETTLE_DEFAULT  1
`endif

// file: pkg/sar_pkg.sv
// types shared by the conversion sequencer modules
package sar_pkg;
  typedef enum logic [2:0] {
    st_acquire,
    st_open_ground,
    st_disconnect,
    st_trial,
    st_finish
  } seq_state_e;
endpackage

// file: pkg/sar_tick_if.sv
// conversion clock tick carrier between the sequencer and its divider
`timescale 1ns/1ps
`default_nettype none
interface sar_tick_if;
  logic enable;
  logic tick;
  modport source (input enable, output tick);
  modport sink   (output enable, input tick);
endinterface
`default_nettype wire

// file: logic/sar_conv_clock.sv
// internal conversion clock: tick generator, runs only while enabled
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_conv_clock
  import sar_pkg::*;
#(
  parameter int divide = `SAR_DIV_DEFAULT
)
(
  input  wire logic    clock,
  input  wire logic    reset,
  sar_tick_if.source   tick_port
);
  typedef struct packed
  {
    logic [7:0] count;
    logic       tick;
  } clk_s;

  clk_s cur;
  clk_s next_cur;

  // the tick counter is eight bits wide
  if (divide < 1 || divide > 255)
  begin : g_bad_divide
    $error("divide out of range");
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    // stopped between conversions so nothing toggles in power-down
    if (!tick_port.enable)
      next_cur.count = 8'h00;
    else if (cur.count == 8'(divide - 1))
    begin
      next_cur.count = 8'h00;
      next_cur.tick  = 1'b1;
    end
    else
      next_cur.count = cur.count + 8'h01;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign tick_port.tick = cur.tick;
endmodule // sar_conv_clock
`default_nettype wire

// file: logic/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer with result saturation
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_conversion_sequencer
  import sar_pkg::*;
#(
  parameter int width  = `SAR_RESOLUTION,
  parameter int divide = `SAR_DIV_DEFAULT
)
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             convert_strobe,
  input  wire logic             comparator_high,
  input  wire logic             over_range,
  input  wire logic             under_range,
  output logic                  pos_sample_ground_switch,
  output logic                  neg_sample_ground_switch,
  output logic                  arrays_on_inputs,
  output logic [width-1:0]      trial_bits,
  output logic                  powered_up,
  output logic                  busy,
  output logic                  done,
  output logic [width-1:0]      result
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    seq_state_e       state;
    logic             strobe_last;
    logic [4:0]       bit_index;
    logic [width-1:0] trial;
    logic             over_seen;
    logic             under_seen;
    logic             ground_closed;
    logic             on_inputs;
    logic             power;
    logic             busy;
    logic             done;
    logic [width-1:0] result;
  } seq_s;

  seq_s cur;
  seq_s next_cur;

  sar_tick_if tick_bus ();

  // refuse sizes that the array and the conversion budget cannot serve
  if (width != `SAR_RESOLUTION)
  begin : g_bad_width
    $error("only the 16-bit array is supported");
  end
  // sixteen trials plus three phase steps must fit the 500 kSPS period
  if ((width + 3) * divide + 2 > `SAR_CONV_PERIOD_CYC)
  begin : g_bad_divide
    $error("divide too large for the conversion rate");
  end

  sar_conv_clock #(
    .divide    (divide)
  ) u_conv_clock (
    .clock     (clock),
    .reset     (reset),
    .tick_port (tick_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // one-hot decode of the bit under trial and of the next lower bit, so the
  // trial word is updated without a variable part-select
  logic [width-1:0] decide_bit;
  logic [width-1:0] lower_bit;

  for (genvar i = 0; i < width; i++)
  begin : g_bit
    assign decide_bit[i] = (cur.bit_index == 5'(i));
    if (i < width - 1)
    begin : g_lower
      assign lower_bit[i] = (cur.bit_index == 5'(i + 1));
    end
    else
    begin : g_top
      assign lower_bit[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // offset-binary trial word flips its top bit into two's complement;
  // over-range wins when both range flags were seen during the trials
  function automatic logic [width-1:0] encode_code
  (
    input logic [width-1:0] word,
    input logic             over,
    input logic             under
  );
    logic [width-1:0] code;
    if (over)
      code = `SAR_CODE_MAX_POS;
    else if (under)
      code = `SAR_CODE_MAX_NEG;
    else
      code = word ^ `SAR_SIGN_FLIP;
    return code;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // phase timing with the default divide of four: ground opens one cycle
  // after the take, the arrays leave the inputs on the second tick, and
  // each of the sixteen ticks after that decides one bit, so done follows
  // the take by 74 cycles, well inside the 200-cycle period at 500 kSPS;
  // the tick divider is stopped whenever the block is powered down
  assign tick_bus.enable = cur.power;

  always_comb
  begin
    next_cur = cur;
    next_cur.strobe_last = convert_strobe;
    next_cur.done = 1'b0;
    case (cur.state)
      st_acquire:
      begin
        if (convert_strobe && !cur.strobe_last)
        begin
          next_cur.state      = st_open_ground;
          next_cur.power      = 1'b1;
          next_cur.busy       = 1'b1;
          next_cur.over_seen  = 1'b0;
          next_cur.under_seen = 1'b0;
        end
      end
      st_open_ground:
      begin
        next_cur.ground_closed = 1'b0;
        if (tick_bus.tick)
          next_cur.state = st_disconnect;
      end
      st_disconnect:
      begin
        if (tick_bus.tick)
        begin
          // arrays leave inputs only after the ground switches are open
          next_cur.on_inputs = 1'b0;
          next_cur.bit_index = 5'(width - 1);
          next_cur.trial     = '0;
          next_cur.trial[width-1] = 1'b1;
          next_cur.state     = st_trial;
        end
      end
      st_trial:
      begin
        // strobe is ignored here so a started conversion always completes
        if (tick_bus.tick)
        begin
          next_cur.over_seen  = cur.over_seen | over_range;
          next_cur.under_seen = cur.under_seen | under_range;
          if (!comparator_high)
            next_cur.trial = cur.trial & ~decide_bit;
          if (cur.bit_index == 5'd0)
            next_cur.state = st_finish;
          else
            next_cur.trial = next_cur.trial | lower_bit;
          next_cur.bit_index = cur.bit_index - 5'd1;
        end
      end
      st_finish:
      begin
        // result, done and busy change together so readout never sees a half word
        next_cur.result        = encode_code(cur.trial, cur.over_seen, cur.under_seen);
        next_cur.done          = 1'b1;
        next_cur.busy          = 1'b0;
        next_cur.ground_closed = 1'b1;
        next_cur.on_inputs     = 1'b1;
        next_cur.power         = 1'b0;
        next_cur.state         = st_acquire;
      end
      default:
        next_cur.state = st_acquire;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cur               <= '0;
      cur.state         <= st_acquire;
      // edge memory starts high so a strobe held across reset does not start
      cur.strobe_last   <= 1'b1;
      cur.ground_closed <= 1'b1;
      cur.on_inputs     <= 1'b1;
      cur.result        <= `SAR_CODE_MIDSCALE;
    end
    else
      cur <= next_cur;
  end

  ////////////////////////////////////////////////////////////////////////
  assign pos_sample_ground_switch = cur.ground_closed;
  assign neg_sample_ground_switch = cur.ground_closed;
  assign arrays_on_inputs         = cur.on_inputs;
  assign trial_bits               = cur.trial;
  assign powered_up               = cur.power;
  assign busy                     = cur.busy;
  assign done                     = cur.done;
  assign result                   = cur.result;
endmodule // sar_conversion_sequencer
`default_nettype wire

// file: testbench/sar_host_model.sv
// host-side model: holds the sampled level and answers each trial
`timescale 1ns/1ps
`default_nettype none
module sar_host_model
(
  input  wire logic        clock,
  input  wire logic        convert_strobe,
  input  wire logic        busy,
  input  wire logic [15:0] level,
  input  wire logic [15:0] trial_bits,
  output logic             comparator_high
);
  logic        last;
  logic [15:0] held;
  // later level changes must not leak into a running conversion
  always_ff @(posedge clock)
  begin
    last <= convert_strobe;
    // only the edge that starts a conversion samples; edges while busy are ignored
    if (convert_strobe && !last && !busy)
      held <= level;
  end
  assign comparator_high = trial_bits <= held;
endmodule // sar_host_model
`default_nettype wire

// file: testbench/sar_seq_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sar_seq_properties
#(
  parameter int width = 16
)
(
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             convert_strobe,
  input wire logic             pos_sample_ground_switch,
  input wire logic             neg_sample_ground_switch,
  input wire logic             arrays_on_inputs,
  input wire logic [width-1:0] trial_bits,
  input wire logic             powered_up,
  input wire logic             busy,
  input wire logic             done,
  input wire logic [width-1:0] result
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  a_strobe_starts: assert property ($rose(convert_strobe) && !busy |=> busy)
    else $error("no start");
  a_ground_first: assert property ($rose(busy) |=> !pos_sample_ground_switch && arrays_on_inputs)
    else $error("ground order");
  a_switch_pair: assert property (pos_sample_ground_switch == neg_sample_ground_switch)
    else $error("switch pair");
  a_msb_first: assert property ($fell(arrays_on_inputs) |-> trial_bits == 16'h8000)
    else $error("first trial");
  a_done_idle: assert property (done |-> !busy && pos_sample_ground_switch && arrays_on_inputs && !powered_up)
    else $error("done state");
  a_rate_bound: assert property ($rose(busy) |-> ##[2:199] $fell(busy))
    else $error("too slow");
  a_result_held: assert property (!done |=> $stable(result) || done)
    else $error("result moved");
  a_busy_powered: assert property (busy |-> powered_up)
    else $error("not powered");
endmodule // sar_seq_properties
bind sar_conversion_sequencer sar_seq_properties #(.width(width)) chk (.clock, .reset, .convert_strobe,
  .pos_sample_ground_switch, .neg_sample_ground_switch, .arrays_on_inputs, .trial_bits, .powered_up,
  .busy, .done, .result);
`default_nettype wire

// file: testbench/tb.sv
// bench: codes, saturation, strobe noise and reset abort
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, reset = 1'b1, convert_strobe = 1'b0, over_range = 1'b0, under_range = 1'b0;
  logic comparator_high, pos_sample_ground_switch, neg_sample_ground_switch;
  logic arrays_on_inputs, powered_up, busy, done;
  logic [15:0] level = 16'h0000, trial_bits, result;
  int err_total = 0, compares = 0;
  initial forever #5 clock = ~clock;
  sar_host_model host (.clock, .convert_strobe, .busy, .level, .trial_bits, .comparator_high);
  sar_conversion_sequencer DUT (.clock, .reset, .convert_strobe, .comparator_high, .over_range,
    .under_range, .pos_sample_ground_switch, .neg_sample_ground_switch, .arrays_on_inputs,
    .trial_bits, .powered_up, .busy, .done, .result);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // level flips after the take so a pipelined design shows the wrong code
  task automatic convert(logic [15:0] lvl, logic ov, logic un, logic [15:0] exp, logic noisy);
    int n;
    level <= lvl;
    over_range <= ov;
    under_range <= un;
    convert_strobe <= 1'b1;
    @(posedge clock);
    level <= ~lvl;
    for (n = 0; n < 300 && done !== 1'b1; n++)
    begin
      @(posedge clock);
      convert_strobe <= noisy && n < 40 && n[2];
    end
    if (n == 300)
    begin
      err_total++;
      test_done;
    end
    check("result", result, exp);
    check("busy", {15'h0, busy}, 16'h0);
    @(posedge clock);
    check("done", {15'h0, done}, 16'h0);
  endtask
  ///////////////////////////////////////////////////////////////////
  task automatic t_codes;
    logic [15:0] lv [6] = '{16'h8000, 16'h8001, 16'h7fff, 16'hffff, 16'h0001, 16'h0000};
    foreach (lv[i])
      convert(lv[i], 1'b0, 1'b0, lv[i] ^ 16'h8000, 1'b0);
  endtask
  task automatic t_saturate;
    convert(16'h4000, 1'b1, 1'b0, 16'h7fff, 1'b0);
    convert(16'hc000, 1'b0, 1'b1, 16'h8000, 1'b0);
    convert(16'h4000, 1'b1, 1'b1, 16'h7fff, 1'b0);
  endtask
  task automatic t_noise;
    convert(16'h1234, 1'b0, 1'b0, 16'h9234, 1'b1);
    repeat (3) @(posedge clock);
    check("restart", {15'h0, busy}, 16'h0);
  endtask
  task automatic t_abort;
    convert_strobe <= 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    convert_strobe <= 1'b0;
    @(posedge clock);
    check("reset result", result, 16'h0000);
    convert(16'h8002, 1'b0, 1'b0, 16'h0002, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_codes;
    t_saturate;
    t_noise;
    t_abort;
    test_done;
  end
endmodule // tb
`default_nettype wire
